// File: rtl/csp_map.vh
/*
 * Register map, strap codes and timing counts for the current share phase
 * manager. Assumes inclusion by bare name from the design files.
 */
`ifndef CSP_MAP_VH
`define CSP_MAP_VH

// ********
// Register byte offsets (AXI4-Lite, one aligned word each)
// ********
`define CSP_OFF_STRAP 8'h00
`define CSP_OFF_CTRL 8'h04
`define CSP_OFF_STATUS 8'h08
`define CSP_OFF_PHASE 8'h0C
`define CSP_OFF_VOLT 8'h10
`define CSP_OFF_IOUT 8'h14
`define CSP_OFF_TEMP 8'h18
`define CSP_OFF_FSW 8'h1C
`define CSP_OFF_FAULTMASK 8'h20
`define CSP_OFF_FAULTSTAT 8'h24
`define CSP_OFF_PEERS 8'h28

// ********
// Control register fields and reset value
// ********
`define CSP_CTRL_CMD_EN 0
`define CSP_CTRL_CMD_VAL 1
`define CSP_CTRL_RESET 32'h00000000

// ********
// Strap codes: index into ascending standard resistor ladder
// ********
`define CSP_STRAP_LOW 6'h3D
`define CSP_STRAP_OPEN 6'h3E
`define CSP_STRAP_HIGH 6'h3F
`define CSP_IDX_10K 6'h00
`define CSP_IDX_19K6 6'h07
`define CSP_IDX_21K5 6'h08
`define CSP_IDX_38K3 6'h0E
`define CSP_IDX_42K2 6'h0F
`define CSP_IDX_82K5 6'h16
`define CSP_IDX_90K9 6'h17
`define CSP_IDX_178K 6'h1E

// Threshold codes
`define CSP_NLR_OFF 2'h0
`define CSP_NLR_3P0 2'h1
`define CSP_NLR_2P0 2'h2
`define CSP_NLR_1P5 2'h3

// ********
// Timing
// ********
`define CSP_CLK_HZ 50000000
`define CSP_DEB_US 1000
`define CSP_DEB_CYC ((`CSP_CLK_HZ / 1000000) * `CSP_DEB_US)

`endif

// File: rtl/csp_phase_mgr.v
/*
 * Current share phase manager: strap decode, phase offset, phase add and
 * drop, reference election, realignment, alert line, AXI4-Lite registers.
 * Assumes one 50 MHz clock; pins and peer bus bits arrive asynchronously.
 */
// Functional notes
// RULE1 - Position strap selects position and sense method
// RULE2 - Count strap selects threshold and member count
// RULE3 - Tied count strap: fixed threshold, sharing off
// RULE4 - Offset is address low bits minus position
// RULE5 - Phases spaced evenly from group offset
// RULE6 - All phases active before power good
// RULE7 - Drop allowed only after power good
// RULE8 - Enable pin low drops, high adds
// RULE9 - Bus command may add or drop phase
// RULE10 - Enable pin change seen within 3 ms
// RULE11 - Lowest active position becomes reference
// RULE12 - Membership change realigns active phases
// RULE13 - After fault all restart together
// RULE14 - Single phase ignores enable pin
// RULE15 - Alert line low on any fault
// RULE16 - Host runs alert response on low
// RULE17 - Host repeats until faults cleared
// RULE18 - Telemetry readable over bus continuously
// RULE19 - Lowest position is reference at start
// RULE20 - At most eight devices per rail
`timescale 1ns/10ps
`default_nettype none
`include "csp_map.vh"

module csp_phase_mgr (
    input wire I_CLK,                 // 50 MHz clock
    input wire I_RESETN,              // Async reset, active low
    input wire I_CE,                  // Clock enable, freezes state when low
    input wire [5:0] I_POS_STRAP,     // Share position strap code
    input wire [5:0] I_CNT_STRAP,     // Share count strap code
    input wire [6:0] I_BUS_ADDR,      // Device bus address
    input wire I_PHASE_ENABLE_PIN,    // Phase enable pin (async)
    input wire I_POWER_GOOD,          // Rail power good (async)
    input wire [7:0] I_FAULTS,        // Fault conditions (async)
    input wire [7:0] I_PEER_ACTIVE,   // Active flags of peers by position
    input wire [31:0] I_TLM_VOLT,     // Input [31:16] / output [15:0] voltage
    input wire [31:0] I_TLM_IOUT,     // Output current
    input wire [31:0] I_TLM_TEMP,     // Internal [31:16] / external [15:0] temp
    input wire [31:0] I_TLM_FSW,      // Switching frequency [31:16] / duty [15:0]
    input wire [31:0] S_AXI_AWADDR,   // Write address
    input wire S_AXI_AWVALID,         // Write address valid
    output reg S_AXI_AWREADY,         // Write address ready
    input wire [31:0] S_AXI_WDATA,    // Write data
    input wire [3:0] S_AXI_WSTRB,     // Write strobes
    input wire S_AXI_WVALID,          // Write data valid
    output reg S_AXI_WREADY,          // Write data ready
    output reg [1:0] S_AXI_BRESP,     // Write response
    output reg S_AXI_BVALID,          // Write response valid
    input wire S_AXI_BREADY,          // Write response ready
    input wire [31:0] S_AXI_ARADDR,   // Read address
    input wire S_AXI_ARVALID,         // Read address valid
    output reg S_AXI_ARREADY,         // Read address ready
    output reg [31:0] S_AXI_RDATA,    // Read data
    output reg [1:0] S_AXI_RRESP,     // Read response
    output reg S_AXI_RVALID,          // Read data valid
    input wire S_AXI_RREADY,          // Read data ready
    output reg O_PHASE_ACTIVE,        // This phase switching
    output reg O_IS_REFERENCE,        // This device is share reference
    output reg [4:0] O_PHASE_ANGLE,   // Phase angle in 22.5 degree steps
    output reg O_RESTART,             // One-cycle common restart pulse
    output reg O_FAULT_ALERT_LINE_O,  // Alert line output level (always 0)
    output reg O_FAULT_ALERT_LINE_OE  // Alert line drive enable, high pulls low
);
    // ********
    // Declarations
    // ********
    wire [2:0] position;              // Decoded position
    wire switch_sense;                // Decoded sense method
    wire [3:0] members;               // Decoded member count
    wire [1:0] nonlinear_response_threshold;                   // Decoded threshold
    wire share_en;                    // Decoded sharing enable
    reg [1:0] pin_s_q;                // Enable pin synchroniser
    reg [1:0] pg_s_q;                 // Power good synchroniser
    reg [7:0] flt_s1_q;               // Fault synchroniser stage 1
    reg [7:0] flt_s2_q;               // Fault synchroniser stage 2
    reg [7:0] peer_s1_q;              // Peer synchroniser stage 1
    reg [7:0] peer_s2_q;              // Peer synchroniser stage 2
    reg pin_q;                        // Debounced enable pin
    reg [15:0] deb_q;                 // Debounce counter
    reg [31:0] ctrl_q;                // Control register
    reg [7:0] fmask_q;                // Fault mask
    reg [7:0] fstat_q;                // Sticky fault status
    reg active_q;                     // Phase active
    reg faulted_q;                    // Rail shut down by fault
    reg [3:0] prev_cnt_q;             // Previous active count
    reg realign_q;                    // Realignment flag, active count changed last cycle
    reg [2:0] rank;                   // Order among active members
    reg [3:0] act_cnt;                // Active member count
    reg [2:0] ref_pos;                // Lowest active position
    reg [7:0] act_vec;                // Active vector incl. self
    reg [4:0] angle;                  // Computed angle
    reg [4:0] step;                   // Angle step
    reg want;                         // Requested enable
    reg [7:0] aw_q;                   // Latched write address
    reg aw_have_q;                    // Write address held
    reg [31:0] wd_q;                  // Latched write data
    reg [3:0] ws_q;                   // Latched strobes
    reg w_have_q;                     // Write data held
    integer i;                        // Loop index
    wire [4:0] group_off;             // Group phase offset
    wire [7:0] flt_now;               // Masked live faults
    wire [31:0] wmask;                // Strobe byte mask
    wire [31:0] ctrl_new;             // Merged control write

    // Strap decoder
    csp_strap_dec u_dec (
        .i_pos_code(I_POS_STRAP),
        .i_cnt_code(I_CNT_STRAP),
        .o_position(position),
        .o_switch_sense(switch_sense),
        .o_members(members),
        .o_nlr(nonlinear_response_threshold),
        .o_share_en(share_en)
    );

    // Offset from address low bits less position (see RULE4)
    assign group_off = I_BUS_ADDR[4:0] - {2'b00, position};
    assign flt_now = flt_s2_q & fmask_q;
    assign wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
    assign ctrl_new = (ctrl_q & ~wmask) | (wd_q & wmask);

    // ********
    // Membership and phase placement
    // ********
    always @* begin
        act_vec = peer_s2_q;
        act_vec[position] = active_q;
        act_cnt = 4'h0;
        rank = 3'h0;
        ref_pos = 3'h0;
        want = 1'b0;
        // Only positions inside the rail size count, max eight (see RULE20)
        for (i = 7; i >= 0; i = i - 1) begin
            if (act_vec[i] && (i < members)) begin
                act_cnt = act_cnt + 4'h1;
                ref_pos = i[2:0];
            end
            if (act_vec[i] && (i < position)) begin
                rank = rank + 3'h1;
            end
        end
        // Even spacing over active members from group offset (see RULE5, RULE12)
        case (act_cnt)
            4'h1: step = 5'h00;
            4'h2: step = 5'h08;
            4'h3: step = 5'h05;
            4'h4: step = 5'h04;
            4'h5: step = 5'h03;
            4'h6: step = 5'h02;
            4'h7: step = 5'h02;
            4'h8: step = 5'h02;
            default: step = 5'h00;
        endcase
        angle = group_off + step * {2'b00, rank};
        // Command overrides pin when enabled (see RULE8, RULE9)
        if (ctrl_q[`CSP_CTRL_CMD_EN]) begin
            want = ctrl_q[`CSP_CTRL_CMD_VAL];
        end else begin
            want = pin_q;
        end
    end

    // ********
    // Synchronisers, debounce, phase state
    // ********
    always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pin_s_q <= 2'b00;
            pg_s_q <= 2'b00;
            flt_s1_q <= 8'h00;
            flt_s2_q <= 8'h00;
            peer_s1_q <= 8'h00;
            peer_s2_q <= 8'h00;
            pin_q <= 1'b1;
            deb_q <= 16'h0000;
            active_q <= 1'b1;
            faulted_q <= 1'b0;
            prev_cnt_q <= 4'h0;
            realign_q <= 1'b0;
            O_PHASE_ACTIVE <= 1'b1;
            O_IS_REFERENCE <= 1'b0;
            O_PHASE_ANGLE <= 5'h00;
            O_RESTART <= 1'b0;
            O_FAULT_ALERT_LINE_O <= 1'b0;
            O_FAULT_ALERT_LINE_OE <= 1'b0;
        end else if (I_CE) begin
            pin_s_q <= {pin_s_q[0], I_PHASE_ENABLE_PIN};
            pg_s_q <= {pg_s_q[0], I_POWER_GOOD};
            flt_s1_q <= I_FAULTS;
            flt_s2_q <= flt_s1_q;
            peer_s1_q <= I_PEER_ACTIVE;
            peer_s2_q <= peer_s1_q;
            // Level must hold 1 ms, well inside 3 ms detect (see RULE10)
            if (pin_s_q[1] == pin_q) begin
                deb_q <= 16'h0000;
            end else if (deb_q == `CSP_DEB_CYC - 1) begin
                pin_q <= pin_s_q[1];
                deb_q <= 16'h0000;
            end else begin
                deb_q <= deb_q + 16'h0001;
            end
            O_RESTART <= 1'b0;
            if (flt_now != 8'h00) begin
                faulted_q <= 1'b1;
            end else if (faulted_q) begin
                // Fault cleared: all members restart together (see RULE13)
                faulted_q <= 1'b0;
                active_q <= 1'b1;
                O_RESTART <= 1'b1;
            end else if (!share_en) begin
                active_q <= 1'b1; // see RULE14
            end else if (!pg_s_q[1]) begin
                active_q <= 1'b1; // see RULE6
            end else begin
                active_q <= want; // see RULE7, RULE8
            end
            prev_cnt_q <= act_cnt;
            realign_q <= (prev_cnt_q != act_cnt);
            O_PHASE_ACTIVE <= active_q && !faulted_q;
            // Lowest active position is reference (see RULE11, RULE19)
            O_IS_REFERENCE <= share_en ? (active_q && ref_pos == position) : 1'b1;
            // Angle refreshed from order among active members (see RULE12)
            O_PHASE_ANGLE <= share_en ? angle : group_off;
            // Pull alert line low on any enabled fault (see RULE15)
            O_FAULT_ALERT_LINE_OE <= (fstat_q != 8'h00) || (flt_now != 8'h00);
        end
    end

    // ********
    // AXI4-Lite write channel and registers
    // ********
    always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'b00;
            aw_q <= 8'h00;
            aw_have_q <= 1'b0;
            wd_q <= 32'h00000000;
            ws_q <= 4'h0;
            w_have_q <= 1'b0;
            ctrl_q <= `CSP_CTRL_RESET;
            fmask_q <= 8'hFF;
            fstat_q <= 8'h00;
        end else if (I_CE) begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_q <= S_AXI_AWADDR[7:0];
                aw_have_q <= 1'b1;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                wd_q <= S_AXI_WDATA;
                ws_q <= S_AXI_WSTRB;
                w_have_q <= 1'b1;
                S_AXI_WREADY <= 1'b0;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
            // Sticky fault capture, set wins over clear (see RULE15, RULE17)
            fstat_q <= fstat_q | flt_now;
            if (aw_have_q && w_have_q && !S_AXI_BVALID) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= 2'b00;
                case ({aw_q[7:2], 2'b00})
                    `CSP_OFF_CTRL: ctrl_q <= ctrl_new; // see RULE9
                    `CSP_OFF_FAULTMASK: fmask_q <= ws_q[0] ? wd_q[7:0] : fmask_q;
                    `CSP_OFF_FAULTSTAT: fstat_q <= (fstat_q & ~(wd_q[7:0] & {8{ws_q[0]}})) | flt_now;
                    `CSP_OFF_STRAP, `CSP_OFF_STATUS, `CSP_OFF_PHASE, `CSP_OFF_VOLT,
                    `CSP_OFF_IOUT, `CSP_OFF_TEMP, `CSP_OFF_FSW, `CSP_OFF_PEERS: S_AXI_BRESP <= 2'b00;
                    default: S_AXI_BRESP <= 2'b10;
                endcase
            end
        end
    end

    // ********
    // AXI4-Lite read channel
    // ********
    always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= 2'b00;
        end else if (I_CE) begin
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= 2'b00;
                // Telemetry words pass straight through (see RULE18)
                case ({S_AXI_ARADDR[7:2], 2'b00})
                    `CSP_OFF_STRAP: S_AXI_RDATA <= {21'h000000, nonlinear_response_threshold, members, switch_sense, share_en, position};
                    `CSP_OFF_CTRL: S_AXI_RDATA <= ctrl_q;
                    `CSP_OFF_STATUS: S_AXI_RDATA <= {23'h000000, realign_q, faulted_q, pg_s_q[1],
                        pin_q, O_IS_REFERENCE, O_PHASE_ACTIVE, ref_pos};
                    `CSP_OFF_PHASE: S_AXI_RDATA <= {15'h0000, act_cnt, rank, O_PHASE_ANGLE, group_off};
                    `CSP_OFF_VOLT: S_AXI_RDATA <= I_TLM_VOLT;
                    `CSP_OFF_IOUT: S_AXI_RDATA <= I_TLM_IOUT;
                    `CSP_OFF_TEMP: S_AXI_RDATA <= I_TLM_TEMP;
                    `CSP_OFF_FSW: S_AXI_RDATA <= I_TLM_FSW;
                    `CSP_OFF_FAULTMASK: S_AXI_RDATA <= {24'h000000, fmask_q};
                    `CSP_OFF_FAULTSTAT: S_AXI_RDATA <= {24'h000000, fstat_q};
                    `CSP_OFF_PEERS: S_AXI_RDATA <= {24'h000000, act_vec};
                    default: begin
                        S_AXI_RDATA <= 32'h00000000;
                        S_AXI_RRESP <= 2'b10;
                    end
                endcase
            end
            if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
                S_AXI_ARREADY <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/csp_strap_dec.v
/*
 * Combinational decoder for the two share straps.
 * Assumes strap codes are stable values from the analog strap reader.
 */
`timescale 1ns/10ps
`default_nettype none
`include "csp_map.vh"

module csp_strap_dec (
    input wire [5:0] i_pos_code,   // Position strap code
    input wire [5:0] i_cnt_code,   // Count strap code
    output reg [2:0] o_position,   // Share position 0..7
    output reg o_switch_sense,     // 1 switch resistance, 0 inductor resistance
    output reg [3:0] o_members,    // Member count, 0 when off
    output reg [1:0] o_nlr,        // Nonlinear response threshold code
    output reg o_share_en          // Sharing enabled
);
    reg [5:0] off;                 // Offset within band

    // ********
    // Decode both straps
    // ********
    always @* begin
        off = 6'h00;
        o_position = 3'h0;
        o_switch_sense = 1'b0;
        // Position strap: two bands of eight values (see RULE1)
        if (i_pos_code <= `CSP_IDX_19K6) begin
            o_position = i_pos_code[2:0];
        end else if (i_pos_code >= `CSP_IDX_42K2 && i_pos_code <= `CSP_IDX_82K5) begin
            off = i_pos_code - `CSP_IDX_42K2;
            o_position = off[2:0];
            o_switch_sense = 1'b1;
        end
        o_members = 4'h0;
        o_nlr = `CSP_NLR_OFF;
        // Count strap: four bands; last value of band one, first of bands three and four disables (see RULE2)
        if (i_cnt_code <= `CSP_IDX_19K6) begin
            off = i_cnt_code;
        end else if (i_cnt_code <= `CSP_IDX_38K3) begin
            o_nlr = `CSP_NLR_3P0;
            off = i_cnt_code - `CSP_IDX_21K5;
        end else if (i_cnt_code <= `CSP_IDX_82K5) begin
            o_nlr = `CSP_NLR_2P0;
            off = i_cnt_code - `CSP_IDX_42K2;
            off = (off == 6'h00) ? 6'h07 : off - 6'h01;
        end else if (i_cnt_code <= `CSP_IDX_178K) begin
            o_nlr = `CSP_NLR_1P5;
            off = i_cnt_code - `CSP_IDX_90K9;
            off = (off == 6'h00) ? 6'h07 : off - 6'h01;
        end else begin
            off = 6'h07;
            // Tied straps: low, open, high (see RULE3)
            if (i_cnt_code == `CSP_STRAP_LOW) begin
                o_nlr = `CSP_NLR_1P5;
            end else if (i_cnt_code == `CSP_STRAP_HIGH) begin
                o_nlr = `CSP_NLR_2P0;
            end
        end
        // Offsets 0..6 give counts 2..8, offset 7 gives zero (see RULE2)
        if (off < 6'h07) begin
            o_members = off[3:0] + 4'h2;
        end
        o_share_en = (o_members != 4'h0);
    end
endmodule
`default_nettype wire

// File: verification/csp_monitor.sv
/* Checker for the phase manager ports.
   Assumes the fault mask stays at its reset value and I_CE is held high. */
`timescale 1ns/10ps
`default_nettype none
`include "csp_map.vh"
module csp_monitor (
    input wire logic I_CLK, // Clock
    input wire logic I_RESETN, // Reset, active low
    input wire logic [5:0] I_CNT_STRAP, // Count strap code
    input wire logic I_POWER_GOOD, // Rail power good
    input wire logic [7:0] I_FAULTS, // Fault levels
    input wire logic S_AXI_AWVALID, // Write address valid
    input wire logic S_AXI_AWREADY, // Write address ready
    input wire logic S_AXI_WVALID, // Write data valid
    input wire logic S_AXI_WREADY, // Write data ready
    input wire logic [1:0] S_AXI_BRESP, // Write response
    input wire logic S_AXI_BVALID, // Write response valid
    input wire logic S_AXI_BREADY, // Write response ready
    input wire logic S_AXI_ARVALID, // Read address valid
    input wire logic S_AXI_ARREADY, // Read address ready
    input wire logic [31:0] S_AXI_RDATA, // Read data
    input wire logic S_AXI_RVALID, // Read data valid
    input wire logic S_AXI_RREADY, // Read data ready
    input wire logic O_PHASE_ACTIVE, // Phase switching
    input wire logic O_RESTART, // Restart pulse
    input wire logic O_FAULT_ALERT_LINE_O, // Alert level
    input wire logic O_FAULT_ALERT_LINE_OE // Alert pull enable
);
    // ********
    // Port relations
    // ********
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);
    // Address and data taken at one edge
    sequence s_wr_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_fault_held;
        (I_FAULTS != 8'h00) [*6];
    endsequence
    a_write_answer: assert property (s_wr_taken |-> ##2 S_AXI_BVALID)
        else $error("write response not on time");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read data not on time");
    a_bresp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    a_rdata_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    a_pre_pg_active: assert property ((!I_POWER_GOOD) [*5] |-> O_PHASE_ACTIVE)
        else $error("phase off before power good");
    a_unshared_active: assert property ((I_CNT_STRAP == `CSP_STRAP_OPEN) [*5] |-> O_PHASE_ACTIVE)
        else $error("unshared phase off");
    a_alert_on_fault: assert property (s_fault_held |-> O_FAULT_ALERT_LINE_OE)
        else $error("alert not pulled on fault");
    a_alert_drive_low: assert property (O_FAULT_ALERT_LINE_O == 1'b0)
        else $error("alert line driven high");
    a_restart_single: assert property (O_RESTART |=> !O_RESTART)
        else $error("restart pulse too long");
endmodule
bind csp_phase_mgr csp_monitor u_mon (.*);
`default_nettype wire

// File: verification/csp_peer_model.sv
/* Peer devices of the share rail and the pulled-up alert wire.
   Assumes the bench chooses which peers stay active. */
`timescale 1ns/10ps
`default_nettype none
module csp_peer_model (
    input wire logic i_clk, // Clock
    input wire logic [7:0] i_want, // Peers kept active
    input wire logic i_alert_oe, // Device pulls alert low
    output logic [7:0] o_peers, // Active flags by position
    output logic o_alert_n // Wired alert level
);
    // Peers change just after an edge, like real logic
    always @(posedge i_clk) begin
        o_peers <= i_want;
    end
    // Pull-up holds the line high unless pulled
    assign o_alert_n = !i_alert_oe;
endmodule
`default_nettype wire

// File: verification/csp_phase_mgr_test.sv
/* Directed bench: AXI4-Lite master tasks and checks of the phase manager.
   Assumes the peer model and bound checker sit beside the device. */
`timescale 1ns/10ps
`default_nettype none
`include "csp_map.vh"
module csp_phase_mgr_test;
    logic clk = 1'b0, rstn = 1'b0, pg = 1'b0, pin = 1'b0, alert_n, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic act, is_ref, restart, al_o, al_oe;
    logic [5:0] pos = 6'h00, cnt = 6'h00;
    logic [7:0] faults = 8'h00, want = 8'h05, peers;
    logic [31:0] volt = 32'h1234ABCD, awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, r_data;
    logic [1:0] bresp, rresp, r_resp, b_resp;
    logic [4:0] angle;
    int n_fail = 0, checked = 0, i, k;
    // Position code, count code, expected strap word
    logic [27:0] tt [0:11] = '{28'h0000048, 28'h070610F, 28'h0F07010, 28'h160825F, 28'h100E319,
        28'h0110449, 28'h021650A, 28'h031E70B, 28'h043D604, 28'h053E005, 28'h063F406, 28'h0018648};
    initial begin
        forever #10 clk = ~clk;
    end
    csp_phase_mgr uut (.I_CLK(clk), .I_RESETN(rstn), .I_CE(1'b1), .I_POS_STRAP(pos), .I_CNT_STRAP(cnt),
        .I_BUS_ADDR(7'h20), .I_PHASE_ENABLE_PIN(pin), .I_POWER_GOOD(pg), .I_FAULTS(faults),
        .I_PEER_ACTIVE(peers), .I_TLM_VOLT(volt), .I_TLM_IOUT(~volt), .I_TLM_TEMP(32'h0), .I_TLM_FSW(32'h0),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .O_PHASE_ACTIVE(act), .O_IS_REFERENCE(is_ref), .O_PHASE_ANGLE(angle),
        .O_RESTART(restart), .O_FAULT_ALERT_LINE_O(al_o), .O_FAULT_ALERT_LINE_OE(al_oe));
    csp_peer_model u_peer (.i_clk(clk), .i_want(want), .i_alert_oe(al_oe), .o_peers(peers), .o_alert_n(alert_n));
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string m);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask
    // A wait that ran out ends the run as a mismatch
    task automatic lim(input int n, input int top);
        if (n >= top) begin
            n_fail++;
            $display("unexpected %0t wait ran out", $time);
            final_report();
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        b_resp = bresp;
        lim(n, 40);
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge clk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        r_data = rdata;
        r_resp = rresp;
        lim(n, 40);
    endtask
    // Pin changes must show within 3 ms, 150000 cycles
    task automatic wait_act(input logic v);
        for (k = 0; k < 150000 && act !== v; k++) @(posedge clk);
        lim(k, 150000);
    endtask
    initial begin
        cyc(2);
        rstn <= 1'b1;
        for (i = 0; i < 12; i++) begin
            pos <= tt[i][25:20];
            cnt <= tt[i][17:12];
            rd(`CSP_OFF_STRAP);
            chk(r_data & 32'h7FF, {20'h0, tt[i][11:0]}, "strap decode");
        end
        pos <= 6'h01;
        cnt <= 6'h02;
        rd(`CSP_OFF_PHASE);
        chk(r_data & 32'h1FC1F, 32'h0641F, "offset rank count");
        chk(angle, 32'h4, "angle of three");
        chk(is_ref, 32'h0, "member role");
        want <= 8'h04;
        cyc(10);
        chk(angle, 32'h1F, "angle of two");
        chk(is_ref, 32'h1, "reference taken over");
        chk(act, 32'h1, "active before power good");
        wr(`CSP_OFF_CTRL, 32'h1);
        cyc(8);
        chk(act, 32'h1, "drop refused");
        pg <= 1'b1;
        cyc(8);
        chk(act, 32'h0, "command drop");
        wr(`CSP_OFF_CTRL, 32'h3);
        cyc(8);
        chk(act, 32'h1, "command add");
        wr(`CSP_OFF_CTRL, 32'h0);
        wait_act(1'b0);
        cnt <= `CSP_STRAP_OPEN;
        cyc(8);
        chk(act, 32'h1, "pin ignored unshared");
        cnt <= 6'h02;
        cyc(8);
        pin <= 1'b1;
        wait_act(1'b1);
        faults <= 8'h01;
        cyc(8);
        chk(alert_n, 32'h0, "alert pulled");
        chk(al_o, 32'h0, "alert level");
        faults <= 8'h00;
        for (k = 0; k < 20 && restart !== 1'b1; k++) @(posedge clk);
        lim(k, 20);
        rd(`CSP_OFF_FAULTSTAT);
        chk(r_data & 32'hFF, 32'h01, "fault source");
        wr(`CSP_OFF_FAULTSTAT, 32'h01);
        cyc(6);
        chk(alert_n, 32'h1, "alert released");
        rd(`CSP_OFF_VOLT);
        chk(r_data, volt, "voltage word");
        rd(`CSP_OFF_IOUT);
        chk(r_data, ~volt, "current word");
        rd(8'h40);
        chk(r_resp, 32'h2, "unmapped read");
        wr(8'h40, 32'h0);
        chk(b_resp, 32'h2, "unmapped write");
        final_report();
    end
endmodule
`default_nettype wire
